// ==== src/pin_mux_pkg.sv ====
// Register map, field layout and select codes of the pin function mux
package pin_mux_pkg;

    // Register offsets (word index on the plain register port)
    localparam logic [3:0] ADDR_PA_DATA  = 4'h0;
    localparam logic [3:0] ADDR_PA_DIR   = 4'h1;
    localparam logic [3:0] ADDR_PA_PULL  = 4'h2;
    localparam logic [3:0] ADDR_PA_DIER  = 4'h3;
    localparam logic [3:0] ADDR_PB_DATA  = 4'h4;
    localparam logic [3:0] ADDR_PB_DIR   = 4'h5;
    localparam logic [3:0] ADDR_PB_PULL  = 4'h6;
    localparam logic [3:0] ADDR_PB_DIER  = 4'h7;
    localparam logic [3:0] ADDR_PA_PINS  = 4'h8;
    localparam logic [3:0] ADDR_PB_PINS  = 4'h9;
    localparam logic [3:0] ADDR_ALT_A    = 4'hA;
    localparam logic [3:0] ADDR_ALT_B    = 4'hB;
    localparam logic [3:0] ADDR_ALT_MISC = 4'hC;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'hD;
    localparam logic [3:0] ADDR_IRQ_CLR  = 4'hE;
    localparam logic [3:0] ADDR_IRQ_EN   = 4'hF;

    // Reset values
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_DIER     = 8'hFF;

    // ALT_A fields: two-bit selects for pins 0, 3, 4 and 5 of port A
    localparam int ALT_A_PA0 = 0;
    localparam int ALT_A_PA3 = 2;
    localparam int ALT_A_PA4 = 4;
    localparam int ALT_A_PA5 = 6;
    // ALT_B fields: two-bit selects for pins 4..7 of port B
    localparam int ALT_B_PB4 = 0;
    localparam int ALT_B_PB5 = 2;
    localparam int ALT_B_PB6 = 4;
    localparam int ALT_B_PB7 = 6;
    // ALT_MISC fields
    localparam int MISC_XTAL      = 0;
    localparam int MISC_PB3_PWMC  = 1;
    localparam int MISC_CMP_PLUS  = 2;
    localparam int MISC_CMP_MSEL  = 3;
    localparam int MISC_CMP_MINUS = 5;

    // Interrupt status bits
    localparam int IRQ_LINE_A = 0;
    localparam int IRQ_LINE_B = 1;
    localparam int IRQ_WAKE   = 2;
    localparam int IRQ_BITS   = 3;

    // Pin function select codes
    typedef enum logic [1:0] {
        SEL_GPIO = 2'h0,
        SEL_F1   = 2'h1,
        SEL_F2   = 2'h2,
        SEL_F3   = 2'h3
    } pin_sel_t;
    // Meaning per pin:
    //  pa0: F1 comparator out, F2 pwm gen a, F3 lcd common b
    //  pa3: F1 timer b pwm,    F2 pwm gen c, F3 lcd common d
    //  pa4: F1 pwm gen c,      F2 lcd common c
    //  pa5: F1 pwm gen c,      F2 hardware reset input
    //  pb4: F1 timer b pwm,    F2 pwm gen a
    //  pb5: F1 timer c pwm,    F2 pwm gen a
    //  pb6/pb7: F1 timer c pwm, F2 pwm gen b

endpackage

// ==== src/sync_2ff.sv ====
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;   // First stage, read only by second stage

    // Both stages reset to zero; pins settle within two cycles after
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ==== src/io_pin_function_mux.sv ====
// Two 8-bit ports with GPIO, wake-up, edge interrupts and alternate routing
`timescale 1ns/1ps
module io_pin_function_mux
    import pin_mux_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // Port pins (five signals per pin)
    input  wire logic [PORT_W-1:0] pa_in,
    output logic      [PORT_W-1:0] pa_out,
    output logic      [PORT_W-1:0] pa_oe,
    output logic      [PORT_W-1:0] pa_pull_en,
    output logic      [PORT_W-1:0] pa_in_en,
    input  wire logic [PORT_W-1:0] pb_in,
    output logic      [PORT_W-1:0] pb_out,
    output logic      [PORT_W-1:0] pb_oe,
    output logic      [PORT_W-1:0] pb_pull_en,
    output logic      [PORT_W-1:0] pb_in_en,
    // Alternate function sources from the core
    input  wire logic              comparator_out,
    input  wire logic              pwm_gen_a_out,
    input  wire logic              pwm_gen_b_out,
    input  wire logic              pwm_gen_c_out,
    input  wire logic              timer_b_pwm_out,
    input  wire logic              timer_c_pwm_out,
    // Analog and special function controls
    output logic                   crystal_en,
    output logic      [2:0]        lcd_bias_en,
    output logic                   comparator_plus_in,
    output logic      [3:0]        comparator_minus_src,
    output logic                   hw_reset_n,
    output logic                   ext_irq_line_a,
    output logic                   ext_irq_line_b,
    output logic                   wake_req,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] pa_data_q, pa_dir_q, pa_pull_q, pa_dier_q;  // Port A
    logic [7:0] pb_data_q, pb_dir_q, pb_pull_q, pb_dier_q;  // Port B
    logic [7:0] alt_a_q, alt_b_q, alt_misc_q;   // Function selects
    logic [IRQ_BITS-1:0] stat_q, en_q;          // Sticky status, enables
    logic [PORT_W-1:0] pa_s, pb_s;              // Synchronised pins
    logic [PORT_W-1:0] pa_prev_q, pb_prev_q;    // Last sampled pins
    logic [PORT_W-1:0] pa_chg, pb_chg;          // Pin changed this cycle
    logic [IRQ_BITS-1:0] ev;                    // Events this cycle
    logic [IRQ_BITS-1:0] clr;                   // Clear strobe bits
    logic [2:0] arm_q;                          // Gates edges after reset
    pin_sel_t sel_pa0, sel_pa3, sel_pa4, sel_pa5;
    pin_sel_t sel_pb4, sel_pb5, sel_pb6, sel_pb7;
    logic [PORT_W-1:0] pa_alt_en, pa_alt_val, pa_off;
    logic [PORT_W-1:0] pb_alt_en, pb_alt_val, pb_off;
    logic [PORT_W-1:0] pa_out_d, pa_oe_d, pb_out_d, pb_oe_d;
    logic [3:0] minus_d;                        // One-hot minus source

    assign sel_pa0 = pin_sel_t'(alt_a_q[ALT_A_PA0 +: 2]);
    assign sel_pa3 = pin_sel_t'(alt_a_q[ALT_A_PA3 +: 2]);
    assign sel_pa4 = pin_sel_t'(alt_a_q[ALT_A_PA4 +: 2]);
    assign sel_pa5 = pin_sel_t'(alt_a_q[ALT_A_PA5 +: 2]);
    assign sel_pb4 = pin_sel_t'(alt_b_q[ALT_B_PB4 +: 2]);
    assign sel_pb5 = pin_sel_t'(alt_b_q[ALT_B_PB5 +: 2]);
    assign sel_pb6 = pin_sel_t'(alt_b_q[ALT_B_PB6 +: 2]);
    assign sel_pb7 = pin_sel_t'(alt_b_q[ALT_B_PB7 +: 2]);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: pins are asynchronous to sys_clk
    sync_2ff #(.WIDTH(PORT_W)) u_sync_pa (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (pa_in),
        .sync_out (pa_s)
    );
    sync_2ff #(.WIDTH(PORT_W)) u_sync_pb (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (pb_in),
        .sync_out (pb_s)
    );

    ////////////////////////////////////////////////////////////////////
    // Software writes to port configuration
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pa_data_q  <= RST_ZERO;
            pa_dir_q   <= RST_ZERO;
            pa_pull_q  <= RST_ZERO;
            pa_dier_q  <= RST_DIER;
            pb_data_q  <= RST_ZERO;
            pb_dir_q   <= RST_ZERO;
            pb_pull_q  <= RST_ZERO;
            pb_dier_q  <= RST_DIER;
            alt_a_q    <= RST_ZERO;
            alt_b_q    <= RST_ZERO;
            alt_misc_q <= RST_ZERO;
            en_q       <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_PA_DATA:  pa_data_q  <= reg_wdata;
                ADDR_PA_DIR:   pa_dir_q   <= reg_wdata;
                ADDR_PA_PULL:  pa_pull_q  <= reg_wdata;
                ADDR_PA_DIER:  pa_dier_q  <= reg_wdata;
                ADDR_PB_DATA:  pb_data_q  <= reg_wdata;
                ADDR_PB_DIR:   pb_dir_q   <= reg_wdata;
                ADDR_PB_PULL:  pb_pull_q  <= reg_wdata;
                ADDR_PB_DIER:  pb_dier_q  <= reg_wdata;
                ADDR_ALT_A:    alt_a_q    <= reg_wdata;
                ADDR_ALT_B:    alt_b_q    <= reg_wdata;
                ADDR_ALT_MISC: alt_misc_q <= reg_wdata;
                ADDR_IRQ_EN:   en_q       <= reg_wdata[IRQ_BITS-1:0];
                default: ;  // Read-only and clear registers store nothing
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= RST_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_PA_DATA:  reg_rdata <= pa_data_q;
                ADDR_PA_DIR:   reg_rdata <= pa_dir_q;
                ADDR_PA_PULL:  reg_rdata <= pa_pull_q;
                ADDR_PA_DIER:  reg_rdata <= pa_dier_q;
                ADDR_PB_DATA:  reg_rdata <= pb_data_q;
                ADDR_PB_DIR:   reg_rdata <= pb_dir_q;
                ADDR_PB_PULL:  reg_rdata <= pb_pull_q;
                ADDR_PB_DIER:  reg_rdata <= pb_dier_q;
                ADDR_PA_PINS:  reg_rdata <= pa_s;
                ADDR_PB_PINS:  reg_rdata <= pb_s;
                ADDR_ALT_A:    reg_rdata <= alt_a_q;
                ADDR_ALT_B:    reg_rdata <= alt_b_q;
                ADDR_ALT_MISC: reg_rdata <= alt_misc_q;
                ADDR_IRQ_STAT: reg_rdata <= {5'h00, stat_q};
                ADDR_IRQ_EN:   reg_rdata <= {5'h00, en_q};
                default:       reg_rdata <= RST_ZERO;  // Clear reads zero
            endcase
        end else begin
            reg_rdata <= RST_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edge and wake detection on synchronised pins
    assign pa_chg = pa_s ^ pa_prev_q;
    assign pb_chg = pb_s ^ pb_prev_q;
    // Synchronisers refill from zero after reset, so the first real pin
    // level would look like an edge; arm_q holds events off until then
    assign ev[IRQ_LINE_A] = pa_chg[0] && arm_q[2];
    assign ev[IRQ_LINE_B] = pb_chg[0] && arm_q[2];
    // Only pins whose input-enable bit is set may wake the core
    assign ev[IRQ_WAKE] = arm_q[2] &&
                          (|(pa_chg & pa_dier_q) | |(pb_chg & pb_dier_q));
    assign clr = (reg_wr && reg_addr == ADDR_IRQ_CLR) ?
                 reg_wdata[IRQ_BITS-1:0] : '0;

    // Previous pin levels and event pulses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arm_q          <= 3'h0;
            pa_prev_q      <= '0;
            pb_prev_q      <= '0;
            ext_irq_line_a <= 1'b0;
            ext_irq_line_b <= 1'b0;
            wake_req       <= 1'b0;
        end else begin
            arm_q          <= {arm_q[1:0], 1'b1};
            pa_prev_q      <= pa_s;
            pb_prev_q      <= pb_s;
            ext_irq_line_a <= ev[IRQ_LINE_A];
            ext_irq_line_b <= ev[IRQ_LINE_B];
            wake_req       <= ev[IRQ_WAKE];
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~clr) | ev;
        end
    end

    assign irq = |(stat_q & en_q);

    ////////////////////////////////////////////////////////////////////
    // Alternate function routing per pin
    always_comb begin
        pa_alt_en  = '0;
        pa_alt_val = '0;
        pa_off     = '0;
        pb_alt_en  = '0;
        pb_alt_val = '0;
        pb_off     = '0;
        minus_d    = 4'h0;
        // Port A bit 0
        case (sel_pa0)
            SEL_F1: begin
                pa_alt_en[0]  = 1'b1;
                pa_alt_val[0] = comparator_out;
            end
            SEL_F2: begin
                pa_alt_en[0]  = 1'b1;
                pa_alt_val[0] = pwm_gen_a_out;
            end
            SEL_F3:  pa_off[0] = 1'b1;
            default: ;
        endcase
        // Port A bit 3
        case (sel_pa3)
            SEL_F1: begin
                pa_alt_en[3]  = 1'b1;
                pa_alt_val[3] = timer_b_pwm_out;
            end
            SEL_F2: begin
                pa_alt_en[3]  = 1'b1;
                pa_alt_val[3] = pwm_gen_c_out;
            end
            SEL_F3:  pa_off[3] = 1'b1;
            default: ;
        endcase
        // Port A bit 4
        case (sel_pa4)
            SEL_F1: begin
                pa_alt_en[4]  = 1'b1;
                pa_alt_val[4] = pwm_gen_c_out;
            end
            SEL_F2:  pa_off[4] = 1'b1;
            default: ;
        endcase
        // Port A bit 5; not reachable under the in-circuit emulator
        case (sel_pa5)
            SEL_F1: begin
                pa_alt_en[5]  = 1'b1;
                pa_alt_val[5] = pwm_gen_c_out;
            end
            SEL_F2:  pa_off[5] = 1'b1;
            default: ;
        endcase
        // Port B bit 3
        if (alt_misc_q[MISC_PB3_PWMC]) begin
            pb_alt_en[3]  = 1'b1;
            pb_alt_val[3] = pwm_gen_c_out;
        end
        // Port B bit 4
        case (sel_pb4)
            SEL_F1: begin
                pb_alt_en[4]  = 1'b1;
                pb_alt_val[4] = timer_b_pwm_out;
            end
            SEL_F2: begin
                pb_alt_en[4]  = 1'b1;
                pb_alt_val[4] = pwm_gen_a_out;
            end
            default: ;
        endcase
        // Port B bit 5
        case (sel_pb5)
            SEL_F1: begin
                pb_alt_en[5]  = 1'b1;
                pb_alt_val[5] = timer_c_pwm_out;
            end
            SEL_F2: begin
                pb_alt_en[5]  = 1'b1;
                pb_alt_val[5] = pwm_gen_a_out;
            end
            default: ;
        endcase
        // Port B bits 6 and 7 share one source set
        pb_alt_en[6]  = (sel_pb6 == SEL_F1) || (sel_pb6 == SEL_F2);
        pb_alt_val[6] = (sel_pb6 == SEL_F1) ? timer_c_pwm_out
                                            : pwm_gen_b_out;
        pb_alt_en[7]  = (sel_pb7 == SEL_F1) || (sel_pb7 == SEL_F2);
        pb_alt_val[7] = (sel_pb7 == SEL_F1) ? timer_c_pwm_out
                                            : pwm_gen_b_out;
        // Crystal pins: drivers off so the oscillator sees no load
        if (alt_misc_q[MISC_XTAL]) begin
            pa_off[7] = 1'b1;
            pa_off[6] = 1'b1;
        end
        // Comparator analog inputs release their pin drivers
        if (alt_misc_q[MISC_CMP_PLUS]) begin
            pa_off[4] = 1'b1;
        end
        if (alt_misc_q[MISC_CMP_MINUS]) begin
            case (alt_misc_q[MISC_CMP_MSEL +: 2])
                2'h0: begin minus_d = 4'h1; pa_off[3] = 1'b1; end
                2'h1: begin minus_d = 4'h2; pb_off[6] = 1'b1; end
                2'h2: begin minus_d = 4'h4; pb_off[7] = 1'b1; end
                default: begin minus_d = 4'h8; pa_off[4] = 1'b1; end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-bit output drivers: alternate wins over port data
    for (genvar i = 0; i < PORT_W; i++) begin : g_bit
        if (i == 5) begin : g_open_drain
            // Open drain: only ever pulls low, high is released
            assign pa_out_d[i] = 1'b0;
            assign pa_oe_d[i]  = !pa_off[i] && (pa_alt_en[i] ?
                                 !pa_alt_val[i] :
                                 (pa_dir_q[i] && !pa_data_q[i]));
        end else begin : g_push_pull
            assign pa_out_d[i] = pa_alt_en[i] ? pa_alt_val[i]
                                              : pa_data_q[i];
            assign pa_oe_d[i]  = !pa_off[i] &&
                                 (pa_alt_en[i] || pa_dir_q[i]);
        end
        assign pb_out_d[i] = pb_alt_en[i] ? pb_alt_val[i]
                                          : pb_data_q[i];
        assign pb_oe_d[i]  = !pb_off[i] && (pb_alt_en[i] || pb_dir_q[i]);
    end

    // Pad controls from flip-flops: one cycle of latency on routed outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pa_out <= '0;
            pa_oe  <= '0;
            pb_out <= '0;
            pb_oe  <= '0;
            pa_pull_en <= '0;
            pb_pull_en <= '0;
            pa_in_en   <= RST_DIER;
            pb_in_en   <= RST_DIER;
        end else begin
            pa_out <= pa_out_d;
            pa_oe  <= pa_oe_d;
            pb_out <= pb_out_d;
            pb_oe  <= pb_oe_d;
            pa_pull_en <= pa_pull_q;
            pb_pull_en <= pb_pull_q;
            pa_in_en   <= pa_dier_q;   // Cleared bits stop leakage
            pb_in_en   <= pb_dier_q;
        end
    end

    // Special function controls
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            crystal_en           <= 1'b0;
            lcd_bias_en          <= 3'h0;
            comparator_plus_in   <= 1'b0;
            comparator_minus_src <= 4'h0;
            hw_reset_n           <= 1'b1;
        end else begin
            crystal_en  <= alt_misc_q[MISC_XTAL];
            lcd_bias_en <= {sel_pa3 == SEL_F3, sel_pa4 == SEL_F2,
                            sel_pa0 == SEL_F3};
            comparator_plus_in   <= alt_misc_q[MISC_CMP_PLUS];
            comparator_minus_src <= minus_d;
            hw_reset_n <= (sel_pa5 != SEL_F2) || pa_s[5];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_GPIO_OUT: assert property (
        1'b1 |=> pa_oe[1] == $past(pa_dir_q[1]) &&
                 pa_out[1] == $past(pa_data_q[1]))
        else $error("port A bit 1 does not follow direction and data");
    AST_PA5_OPEN_DRAIN: assert property (
        1'b1 |=> !pa_out[5] && !(pa_oe[5] && $past(pa_off[5])))
        else $error("port A bit 5 drives high");
    AST_WAKE_GATED: assert property (
        (pa_dier_q == 8'h00 && pb_dier_q == 8'h00) |=> !wake_req)
        else $error("wake raised while all input enables are clear");
    AST_LINE_A_EDGE: assert property (
        ($changed(pa_s[0]) && arm_q[2]) |=> stat_q[IRQ_LINE_A] &&
                                            ext_irq_line_a)
        else $error("edge on port A bit 0 not flagged");
    AST_RESET_PIN: assert property (
        (sel_pa5 == SEL_F2 && !pa_s[5]) |=> !hw_reset_n && !pa_oe[5])
        else $error("reset input not passed through");
    AST_CMP_OUT: assert property (
        sel_pa0 == SEL_F1 |=> pa_oe[0] && pa_out[0] == $past(comparator_out))
        else $error("comparator result not on port A bit 0");
    AST_PWM_A_PB4: assert property (
        sel_pb4 == SEL_F2 |=> pb_oe[4] && pb_out[4] == $past(pwm_gen_a_out))
        else $error("pwm gen a not routed to port B bit 4");
    AST_PWM_B_PB7: assert property (
        (sel_pb7 == SEL_F2 && !alt_misc_q[MISC_CMP_MINUS])
        |=> pb_oe[7] && pb_out[7] == $past(pwm_gen_b_out))
        else $error("pwm gen b not routed to port B bit 7");
    AST_LCD_PA3: assert property (
        sel_pa3 == SEL_F3 |=> lcd_bias_en[2] && !pa_oe[3])
        else $error("lcd common on port A bit 3 still driven");
    AST_LINE_B_EDGE: assert property (
        ($changed(pb_s[0]) && arm_q[2]) |=> stat_q[IRQ_LINE_B] ##1
        (stat_q[IRQ_LINE_B] || $past(clr[IRQ_LINE_B])))
        else $error("edge on port B bit 0 not held sticky");

    COV_WAKE:  cover property (wake_req);
    COV_IRQ:   cover property (irq ##1 !irq);
    COV_RESET: cover property (!hw_reset_n ##1 hw_reset_n);

endmodule

// ==== sim/board_model.sv ====
// Board side of both ports: pull-ups, bench drivers, floating lines
`timescale 1ns/1ps
module board_model (
    input  wire logic [15:0] drv_out,
    input  wire logic [15:0] drv_oe,
    input  wire logic [15:0] pull_en,
    input  wire logic [15:0] ext_val,
    input  wire logic [15:0] ext_en,
    output logic      [15:0] pad
);
    // Chip drive wins; a floating line reads high if pulled, else inverted so stale never passes
    assign pad = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val)
        | (~drv_oe & ~ext_en & (pull_en | ~drv_out));
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench of the pin function mux
`timescale 1ns/1ps
module testbench import pin_mux_pkg::*; ;
    logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq;
    logic [3:0] reg_addr = 4'h0, comparator_minus_src;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, pa_in, pa_out, pa_oe, pa_pull_en;
    logic [7:0] pa_in_en, pb_in, pb_out, pb_oe, pb_pull_en, pb_in_en;
    logic comparator_out = 1'b1, pwm_gen_a_out = 1'b1, pwm_gen_b_out = 1'b1;
    logic pwm_gen_c_out = 1'b1, timer_b_pwm_out = 1'b1, timer_c_pwm_out = 1'b1;
    logic crystal_en, comparator_plus_in, hw_reset_n, ext_irq_line_a;
    logic ext_irq_line_b, wake_req;
    logic [2:0] lcd_bias_en;
    logic [15:0] ext_val = 16'h0000, ext_en = 16'hFFFF;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    logic [47:0] rows [7] = '{48'h01_00_00_01_FF_00, 48'h02_00_00_01_FF_00,
        48'h14_00_00_18_FF_00, 48'h48_00_00_08_DF_00, 48'h00_55_00_00_FF_F0,
        48'h00_AA_00_00_FF_F0, 48'h00_00_02_00_FF_08};
    always #20 sys_clk = ~sys_clk;
    io_pin_function_mux dut_u (.*);
    board_model board_u (.drv_out({pb_out, pa_out}), .drv_oe({pb_oe, pa_oe}),
        .pull_en({pb_pull_en, pa_pull_en}), .ext_val, .ext_en,
        .pad({pb_in, pa_in}));
    task automatic chk(input string nm, input logic [7:0] e, g);
        cmp_count++;
        error_cnt += (g !== e);
        if (g !== e) $display("[ERR] %s expected %h seen %h", nm, e, g);
    endtask
    // Strobes drop at the edge that takes them
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Pads pass two syncs, so events show three edges later
    task automatic pins(input logic [15:0] v);
        @(posedge sys_clk);
        ext_val <= v;
        settle(5);
    endtask
    // Pulses stand one cycle, three edges after the pad change
    task automatic pulse(input logic [15:0] v, input logic [7:0] e);
        @(posedge sys_clk);
        ext_val <= v;
        settle(3);
        chk("pulses", e, {5'h00, wake_req, ext_irq_line_b, ext_irq_line_a});
        settle(1);
        chk("pulses", 8'h00, {5'h00, wake_req, ext_irq_line_b, ext_irq_line_a});
    endtask
    task automatic final_report(input int late);
        error_cnt += late;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) final_report(1);
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(ADDR_PA_DIER, RST_DIER, "pa_dier");
        wr(ADDR_PA_DIR, 8'hFF);
        wr(ADDR_PA_DATA, 8'hFF);
        settle(2);
        chk("pa_out", 8'hDF, pa_out);
        chk("pa_oe", 8'hDF, pa_oe);
        wr(ADDR_PA_DATA, 8'h00);
        // Sources high and data low, so a routed push-pull pin shows a one
        foreach (rows[i]) begin
            wr(ADDR_ALT_A, rows[i][47:40]);
            wr(ADDR_ALT_B, rows[i][39:32]);
            wr(ADDR_ALT_MISC, rows[i][31:24]);
            settle(2);
            chk("pa_out", rows[i][23:16], pa_out);
            chk("pa_oe", rows[i][15:8], pa_oe);
            chk("pb_out", rows[i][7:0], pb_out);
            chk("pb_oe", rows[i][7:0], pb_oe);
        end
        wr(ADDR_PA_DIER, 8'h3F);
        wr(ADDR_ALT_A, 8'h2F);
        wr(ADDR_ALT_MISC, 8'h05);
        settle(2);
        chk("lcd_bias_en", 8'h07, {5'h00, lcd_bias_en});
        chk("pa_oe", 8'h26, pa_oe);
        chk("crystal_en", 8'h01, {7'h00, crystal_en});
        chk("cmp_plus", 8'h01, {7'h00, comparator_plus_in});
        chk("pa_in_en", 8'h3F, pa_in_en);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_ALT_MISC, {2'b00, 1'b1, s[1:0], 3'b000});
            settle(2);
            chk("minus_src", 8'h01 << s, {4'h0, comparator_minus_src});
        end
        $display("gpio, routing and analog tests done");
        wr(ADDR_ALT_A, 8'h00);
        wr(ADDR_PA_DIR, 8'h00);
        pins(16'h3C25);
        rdc(ADDR_PA_PINS, 8'h25, "pa_pins");
        wr(ADDR_IRQ_EN, 8'h03);
        wr(ADDR_IRQ_CLR, 8'h07);
        pulse(16'h3D24, 8'h07);
        rdc(ADDR_IRQ_STAT, 8'h07, "irq_stat");
        chk("irq", 8'h01, {7'h00, irq});
        wr(ADDR_IRQ_CLR, 8'h07);
        pins(16'h3D64);
        rdc(ADDR_IRQ_STAT, 8'h00, "irq_stat");
        wr(ADDR_PA_DIER, 8'h00);
        wr(ADDR_PB_DIER, 8'h00);
        pulse(16'h3C64, 8'h02);
        chk("pb_in_en", 8'h00, pb_in_en);
        wr(ADDR_PB_PULL, 8'hA5);
        wr(ADDR_ALT_A, 8'h80);
        pins(16'h3D44);
        chk("pb_pull_en", 8'hA5, pb_pull_en);
        chk("hw_reset_n", 8'h00, {7'h00, hw_reset_n});
        $display("pin event tests done");
        // Mid-run reset: pins stay put, so no false edge may be flagged
        @(posedge sys_clk);
        rst <= 1'b1;
        settle(3);
        chk("pa_in_en", RST_DIER, pa_in_en);
        chk("pa_oe", 8'h00, pa_oe);
        chk("hw_reset_n", 8'h01, {7'h00, hw_reset_n});
        @(posedge sys_clk);
        rst <= 1'b0;
        settle(4);
        rdc(ADDR_IRQ_STAT, 8'h00, "irq_stat");
        chk("pb_pull_en", 8'h00, pb_pull_en);
        $display("reset tests done");
        final_report(0);
    end
endmodule
